// *** rtl/evt_sig_defs.vh ***
// constants, register map and timing for the event capture and signaling block
// Function
// [R1] Some events are captured regardless of enables
// [R2] Other events each have their own enable
// [R3] Enabled event sets sticky status bit
// [R4] Receive pins go low on pending event
// [R5] Enabled event in sleep leaves sleep
// [R6] CAN state follows field only in normal; code also passes field 10 (biased) outside normal
// [R7] CAN pin carries bus when field 01/11
// [R8] LIN pin carries bus when field 10
// [R9] Summary register shows pending event categories
// [R10] Writing one clears status, zero keeps
// [R11] One write clears several bits together
// [R12] Host clears only bits it read set
// [R13] Clearing status releases pin, starts hold-off
// [R14] Hold-off keeps pin high, events still captured
// [R15] At expiry pin low if events pending
// [R16] At expiry pin stays high if none
// [R17] Status reads have no side effects
// [R18] Sleep request falls back to standby unless safe
// [R19] Read-only identification byte at 0x7e
// [R20] Lock blocks port writes, not hardware updates; code still lets status clear writes through
// [R21] Events stored and signalled on receive pins
// [R22] Events are regular wake-ups or interrupts
// [R23] Hold-off time is a cycle-count parameter
// [R24] Idle hold-off: pin low iff pending and idle
`ifndef EVT_SIG_DEFS_VH
`define EVT_SIG_DEFS_VH

// register offsets on the serial register port
`define ADDR_DEV_MODE 7'h01
`define ADDR_SYS_CAP_EN 7'h04
`define ADDR_CAN_MODE 7'h22
`define ADDR_TRX_CAP_EN 7'h23
`define ADDR_LIN_MODE 7'h26
`define ADDR_WAKE_CAP_EN 7'h4c
`define ADDR_EVT_SUMMARY 7'h60
`define ADDR_SYS_STATUS 7'h61
`define ADDR_TRX_STATUS 7'h63
`define ADDR_WAKE_STATUS 7'h64
`define ADDR_DEV_ID 7'h7e

// events that ignore their capture enable, per group
`define SYS_ALWAYS_MASK 8'hff
`define TRX_ALWAYS_MASK 8'h0c
`define WAKE_ALWAYS_MASK 8'h00

// field positions of regular wake-up events
`define TRX_CAN_WAKE_BIT 0
`define TRX_LIN_WAKE_BIT 1
`define WAKE_RISE_BIT 0
`define WAKE_FALL_BIT 1

// summary register bits
`define SUM_SYS_BIT 0
`define SUM_TRX_BIT 1
`define SUM_WAKE_BIT 2

// device mode codes
`define DEV_MODE_SLEEP 3'h1
`define DEV_MODE_STANDBY 3'h4
`define DEV_MODE_NORMAL 3'h7

// transceiver mode codes
`define CAN_MODE_STANDBY 2'h0
`define CAN_MODE_NORMAL 2'h1
`define CAN_MODE_BIASED 2'h2
`define CAN_MODE_SILENT 2'h3
`define LIN_MODE_NORMAL 2'h2
`define LIN_MODE_STANDBY 2'h0

// reset values
`define CAP_EN_RESET 8'h00
`define CAN_MODE_RESET 2'h0
`define LIN_MODE_RESET 2'h0

// identification byte, both nibbles arbitrary
`define ID_FAMILY_CODE 4'h5
`define ID_PRODUCT_CODE 4'h1

// hold-off timing: least time, rounded up to whole cycles
`define CLK_PERIOD_NS 25
`define HOLDOFF_TIME_NS 50000
`define HOLDOFF_CYCLES ((`HOLDOFF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/evt_status_group.v ***
// one group of sticky event status bits with write-one-to-clear
`timescale 1ns/1ps
module evt_status_group #(
	parameter W = 8,
	parameter [7:0] ALWAYS_MASK = 8'h00
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [W-1:0] evt_i,
	input wire [W-1:0] cap_en_i,
	input wire [W-1:0] clr_i,
	output wire [W-1:0] status_o,
	output wire cleared_o,
	output wire new_o
);

wire [W-1:0] capture;
wire [W-1:0] bit_cleared;
wire [W-1:0] bit_new;
reg [W-1:0] status_r;

genvar i;
generate
	for (i = 0; i < W; i = i + 1)
	begin : g_bit
		// always-captured events bypass the enable
		assign capture[i] = evt_i[i] & (cap_en_i[i] | ALWAYS_MASK[i]); // see [R1] see [R2]
		// a bit only counts as cleared when it was set and no event refills it
		assign bit_cleared[i] = status_r[i] & clr_i[i] & ~capture[i];
		assign bit_new[i] = capture[i] & ~status_r[i];
		// set wins over clear so a racing event is never lost
		always @(posedge sys_clk_i or negedge rst_n_i)
		begin
			if (!rst_n_i)
				status_r[i] <= 1'b0;
			else if (capture[i])
				status_r[i] <= 1'b1; // see [R3] see [R20]
			else if (clr_i[i])
				status_r[i] <= 1'b0; // see [R10] see [R11]
		end
	end
endgenerate

assign status_o = status_r;
assign cleared_o = |bit_cleared;
assign new_o = |bit_new;

endmodule

// *** rtl/evt_holdoff_timer.v ***
// retriggerable hold-off timer for the event indicator pins
`timescale 1ns/1ps
module evt_holdoff_timer #(
	parameter CYCLES = 2000,
	parameter CW = 16
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire start_i,
	output wire busy_o
);

reg [CW-1:0] count_r;
reg [CW-1:0] count_nxt;

// a new clear restarts the full delay
always @*
begin
	count_nxt = count_r;
	if (start_i)
		count_nxt = CYCLES[CW-1:0]; // see [R13] see [R23]
	else if (count_r != {CW{1'b0}})
		count_nxt = count_r - {{(CW-1){1'b0}}, 1'b1};
end

always @(posedge sys_clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
		count_r <= {CW{1'b0}};
	else
		count_r <= count_nxt;
end

assign busy_o = (count_r != {CW{1'b0}});

endmodule

// *** rtl/event_capture_and_signaling.v ***
// event capture, receive pin signaling, mode guard and id byte
`timescale 1ns/1ps
`include "evt_sig_defs.vh"
module event_capture_and_signaling #(
	parameter HOLDOFF_CYCLES = `HOLDOFF_CYCLES,
	parameter [3:0] PRODUCT_CODE = `ID_PRODUCT_CODE
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [6:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire wr_lock_i,
	output wire [7:0] reg_rdata_o,
	input wire [7:0] sys_evt_i,
	input wire [7:0] trx_evt_i,
	input wire [7:0] wake_evt_i,
	input wire vcc_ok_i,
	input wire can_rx_bus_i,
	input wire lin_rx_bus_i,
	output wire rxd_o,
	output wire rxd_lin_o,
	output wire [1:0] can_state_o,
	output wire [1:0] lin_state_o,
	output wire [2:0] dev_mode_o,
	output wire holdoff_busy_o
);

// device operating states, one-hot
localparam [2:0] ST_STANDBY = 3'b001;
localparam [2:0] ST_SLEEP = 3'b010;
localparam [2:0] ST_NORMAL = 3'b100;

localparam HCW = 16;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [7:0] sys_en_r;
reg [7:0] trx_en_r;
reg [7:0] wake_en_r;
reg [1:0] can_field_r;
reg [1:0] lin_field_r;
reg [7:0] rdata_r;
reg [7:0] rdata_nxt;
reg rxd_r;
reg rxd_lin_r;
reg [1:0] can_state_r;
reg [1:0] lin_state_r;

wire [7:0] sys_status;
wire [7:0] trx_status;
wire [7:0] wake_status;
wire [2:0] summary;
wire [7:0] sys_clr;
wire [7:0] trx_clr;
wire [7:0] wake_clr;
wire sys_cleared;
wire trx_cleared;
wire wake_cleared;
wire sys_new;
wire trx_new;
wire wake_new;
wire any_pending;
wire any_cleared;
wire any_new;
wire regular_enabled;
wire sleep_ok;
wire cfg_wr;
wire busy;
wire can_stream;
wire lin_stream;
wire indicate;

// true when the written address matches and the port may write
function wr_hit;
	input [6:0] addr;
	input [6:0] target;
	input wr;
	begin
		wr_hit = wr & (addr == target);
	end
endfunction

// CAN receive pin carries bus data only in normal with normal or silent
function can_passes;
	input [2:0] st;
	input [1:0] field;
	begin
		can_passes = (st == ST_NORMAL) &&
			((field == `CAN_MODE_NORMAL) || (field == `CAN_MODE_SILENT)); // see [R7]
	end
endfunction

// status clears are never locked; configuration writes are
assign cfg_wr = reg_wr_i & ~wr_lock_i; // see [R20]

// write-one-to-clear masks, several bits at once
assign sys_clr = wr_hit(reg_addr_i, `ADDR_SYS_STATUS, reg_wr_i) ? reg_wdata_i : 8'h00; // see [R11]
assign trx_clr = wr_hit(reg_addr_i, `ADDR_TRX_STATUS, reg_wr_i) ? reg_wdata_i : 8'h00;
assign wake_clr = wr_hit(reg_addr_i, `ADDR_WAKE_STATUS, reg_wr_i) ? reg_wdata_i : 8'h00;

evt_status_group #(
	.W(8),
	.ALWAYS_MASK(`SYS_ALWAYS_MASK)
) u_sys_group (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.evt_i(sys_evt_i),
	.cap_en_i(sys_en_r),
	.clr_i(sys_clr),
	.status_o(sys_status),
	.cleared_o(sys_cleared),
	.new_o(sys_new)
);

evt_status_group #(
	.W(8),
	.ALWAYS_MASK(`TRX_ALWAYS_MASK)
) u_trx_group (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.evt_i(trx_evt_i),
	.cap_en_i(trx_en_r),
	.clr_i(trx_clr),
	.status_o(trx_status),
	.cleared_o(trx_cleared),
	.new_o(trx_new)
);

evt_status_group #(
	.W(8),
	.ALWAYS_MASK(`WAKE_ALWAYS_MASK)
) u_wake_group (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.evt_i(wake_evt_i),
	.cap_en_i(wake_en_r),
	.clr_i(wake_clr),
	.status_o(wake_status),
	.cleared_o(wake_cleared),
	.new_o(wake_new)
);

// category summary for fast polling
assign summary[`SUM_SYS_BIT] = |sys_status; // see [R9]
assign summary[`SUM_TRX_BIT] = |trx_status;
assign summary[`SUM_WAKE_BIT] = |wake_status;

assign any_pending = |summary; // see [R21]
assign any_cleared = sys_cleared | trx_cleared | wake_cleared;
assign any_new = sys_new | trx_new | wake_new;

// only bus and wake pin wake-ups count as regular wake-up sources
assign regular_enabled = trx_en_r[`TRX_CAN_WAKE_BIT] | trx_en_r[`TRX_LIN_WAKE_BIT] |
	wake_en_r[`WAKE_RISE_BIT] | wake_en_r[`WAKE_FALL_BIT]; // see [R22]
assign sleep_ok = regular_enabled & ~any_pending; // see [R18]

evt_holdoff_timer #(
	.CYCLES(HOLDOFF_CYCLES),
	.CW(HCW)
) u_holdoff (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.start_i(any_cleared),
	.busy_o(busy)
);

// configuration registers; the port lock stops these and device mode writes, not status clears
always @(posedge sys_clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		sys_en_r <= `CAP_EN_RESET;
		trx_en_r <= `CAP_EN_RESET;
		wake_en_r <= `CAP_EN_RESET;
		can_field_r <= `CAN_MODE_RESET;
		lin_field_r <= `LIN_MODE_RESET;
	end
	else
	begin
		if (wr_hit(reg_addr_i, `ADDR_SYS_CAP_EN, cfg_wr))
			sys_en_r <= reg_wdata_i; // see [R2]
		if (wr_hit(reg_addr_i, `ADDR_TRX_CAP_EN, cfg_wr))
			trx_en_r <= reg_wdata_i;
		if (wr_hit(reg_addr_i, `ADDR_WAKE_CAP_EN, cfg_wr))
			wake_en_r <= reg_wdata_i;
		if (wr_hit(reg_addr_i, `ADDR_CAN_MODE, cfg_wr))
			can_field_r <= reg_wdata_i[1:0];
		if (wr_hit(reg_addr_i, `ADDR_LIN_MODE, cfg_wr))
			lin_field_r <= reg_wdata_i[1:0];
	end
end

// device mode: a wake event in sleep beats a mode write in the same cycle
always @*
begin
	state_nxt = state_r;
	case (state_r)
		ST_SLEEP:
		begin
			if (any_new)
				state_nxt = ST_STANDBY; // see [R5]
			else if (wr_hit(reg_addr_i, `ADDR_DEV_MODE, cfg_wr))
			begin
				if (reg_wdata_i[2:0] == `DEV_MODE_STANDBY)
					state_nxt = ST_STANDBY;
				else if (reg_wdata_i[2:0] == `DEV_MODE_NORMAL)
					state_nxt = ST_NORMAL;
			end
		end
		ST_STANDBY, ST_NORMAL:
		begin
			if (wr_hit(reg_addr_i, `ADDR_DEV_MODE, cfg_wr))
			begin
				if (reg_wdata_i[2:0] == `DEV_MODE_SLEEP)
					state_nxt = sleep_ok ? ST_SLEEP : ST_STANDBY; // see [R18]
				else if (reg_wdata_i[2:0] == `DEV_MODE_STANDBY)
					state_nxt = ST_STANDBY;
				else if (reg_wdata_i[2:0] == `DEV_MODE_NORMAL)
					state_nxt = ST_NORMAL;
			end
		end
		default:
			state_nxt = ST_STANDBY;
	endcase
end

always @(posedge sys_clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
		state_r <= ST_STANDBY;
	else
		state_r <= state_nxt;
end

// pin sources: bus data or event indicator
assign can_stream = can_passes(state_r, can_field_r);
assign lin_stream = (state_r == ST_NORMAL) && (lin_field_r == `LIN_MODE_NORMAL); // see [R8]
// indicator held off while the timer runs; pulled low only with vcc present
assign indicate = any_pending & vcc_ok_i & ~busy & ~any_cleared; // see [R4] see [R14]

// pins and transceiver states are registered for glitch-free outputs
always @(posedge sys_clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
	begin
		rxd_r <= 1'b1;
		rxd_lin_r <= 1'b1;
		can_state_r <= `CAN_MODE_STANDBY;
		lin_state_r <= `LIN_MODE_STANDBY;
	end
	else
	begin
		rxd_r <= can_stream ? can_rx_bus_i : ~indicate; // see [R13] see [R15] see [R16] see [R24]
		rxd_lin_r <= lin_stream ? lin_rx_bus_i : ~indicate; // see [R24]
		if (state_r == ST_NORMAL)
			can_state_r <= can_field_r; // see [R6]
		else if (can_field_r == `CAN_MODE_BIASED)
			can_state_r <= `CAN_MODE_BIASED;
		else
			can_state_r <= `CAN_MODE_STANDBY; // see [R6]
		lin_state_r <= lin_stream ? `LIN_MODE_NORMAL : `LIN_MODE_STANDBY;
	end
end

// read mux; reads never touch status contents
always @*
begin
	case (reg_addr_i)
		`ADDR_DEV_MODE:
			rdata_nxt = {5'h00, dev_mode_o};
		`ADDR_SYS_CAP_EN:
			rdata_nxt = sys_en_r;
		`ADDR_CAN_MODE:
			rdata_nxt = {6'h00, can_field_r};
		`ADDR_TRX_CAP_EN:
			rdata_nxt = trx_en_r;
		`ADDR_LIN_MODE:
			rdata_nxt = {6'h00, lin_field_r};
		`ADDR_WAKE_CAP_EN:
			rdata_nxt = wake_en_r;
		`ADDR_EVT_SUMMARY:
			rdata_nxt = {5'h00, summary}; // see [R9]
		`ADDR_SYS_STATUS:
			rdata_nxt = sys_status; // see [R17]
		`ADDR_TRX_STATUS:
			rdata_nxt = trx_status;
		`ADDR_WAKE_STATUS:
			rdata_nxt = wake_status;
		`ADDR_DEV_ID:
			rdata_nxt = {`ID_FAMILY_CODE, PRODUCT_CODE}; // see [R19]
		default:
			rdata_nxt = 8'h00;
	endcase
end

always @(posedge sys_clk_i or negedge rst_n_i)
begin
	if (!rst_n_i)
		rdata_r <= 8'h00;
	else if (reg_rd_i)
		rdata_r <= rdata_nxt;
end

assign reg_rdata_o = rdata_r;
assign rxd_o = rxd_r;
assign rxd_lin_o = rxd_lin_r;
assign can_state_o = can_state_r;
assign lin_state_o = lin_state_r;
assign dev_mode_o = (state_r == ST_SLEEP) ? `DEV_MODE_SLEEP :
	(state_r == ST_NORMAL) ? `DEV_MODE_NORMAL : `DEV_MODE_STANDBY;
assign holdoff_busy_o = busy;

endmodule

// *** dv/evt_sig_monitor.sv ***
// assertions on the ports of the event capture and signaling block
`timescale 1ns/1ps
module evt_sig_monitor #(
	parameter HOLDOFF_CYCLES = 8
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [6:0] reg_addr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_rdata_o,
	input wire [7:0] trx_evt_i,
	input wire vcc_ok_i,
	input wire can_rx_bus_i,
	input wire lin_rx_bus_i,
	input wire rxd_o,
	input wire rxd_lin_o,
	input wire [1:0] can_state_o,
	input wire [1:0] lin_state_o,
	input wire [2:0] dev_mode_o,
	input wire holdoff_busy_o
);
	reg [15:0] busy_cnt_r;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// length of the running hold-off; a retrigger only makes it longer
	always @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			busy_cnt_r <= 16'h0000;
		else
			busy_cnt_r <= holdoff_busy_o ? busy_cnt_r + 16'h0001 : 16'h0000;
	end
	chk_id_fixed: assert property (reg_rd_i && reg_addr_i == 7'h7e |=> reg_rdata_o == 8'h51)
		else $error("id byte wrong");
	chk_clear_release: assert property ($rose(holdoff_busy_o) && dev_mode_o != 3'h7
		|-> rxd_o && rxd_lin_o)
		else $error("pin low when hold-off starts");
	chk_holdoff_len: assert property ($fell(holdoff_busy_o) |-> busy_cnt_r >= HOLDOFF_CYCLES)
		else $error("hold-off too short");
	chk_holdoff_quiet: assert property (holdoff_busy_o && $past(holdoff_busy_o)
		&& dev_mode_o == 3'h4 && $past(dev_mode_o) == 3'h4 |-> rxd_o && rxd_lin_o)
		else $error("pin low during hold-off");
	chk_pin_indicates: assert property ($rose(trx_evt_i[2]) && vcc_ok_i && !holdoff_busy_o
		&& dev_mode_o == 3'h4 |-> ##2 holdoff_busy_o || (!rxd_o && !rxd_lin_o))
		else $error("event not indicated");
	chk_can_stream: assert property (dev_mode_o == 3'h7 && can_state_o[0] ##1
		dev_mode_o == 3'h7 && can_state_o[0] |-> rxd_o == $past(can_rx_bus_i))
		else $error("can pin not following bus");
	chk_lin_stream: assert property (lin_state_o == 2'h2 [*2] |-> rxd_lin_o == $past(lin_rx_bus_i))
		else $error("lin pin not following bus");
	chk_sleep_wake: assert property (dev_mode_o == 3'h1 && trx_evt_i[2] |-> ##[1:3] dev_mode_o == 3'h4)
		else $error("no wake from sleep");
endmodule

bind event_capture_and_signaling evt_sig_monitor #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) mon_u (
	.sys_clk_i, .rst_n_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .trx_evt_i, .vcc_ok_i,
	.can_rx_bus_i, .lin_rx_bus_i, .rxd_o, .rxd_lin_o, .can_state_o, .lin_state_o,
	.dev_mode_o, .holdoff_busy_o);

// *** dv/evt_host_model.sv ***
// host microcontroller model: register port accesses
`timescale 1ns/1ps
module evt_host_model (
	input wire sys_clk_i,
	input wire [7:0] rdata_i,
	output logic [6:0] addr_o = 7'h00,
	output logic [7:0] wdata_o = 8'h00,
	output logic wr_o = 1'b0,
	output logic rd_o = 1'b0
);
	// one-cycle write strobe; address and data hold through the taken edge
	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge sys_clk_i);
		wr_o <= 1'b0;
	endtask
	// read data is registered, so it is taken one edge after the strobe
	task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge sys_clk_i);
		rd_o <= 1'b0;
		@(posedge sys_clk_i);
		d = rdata_i;
	endtask
	// acknowledge only what was seen set, so a late event is not wiped
	task automatic ack_reg(input logic [6:0] a, output logic [7:0] d);
		rd_reg(a, d);
		if (d !== 8'h00)
			wr_reg(a, d);
	endtask
endmodule

// *** dv/event_capture_and_signaling_tb_top.sv ***
// self-checking bench for the event capture and signaling block
`timescale 1ns/1ps
module event_capture_and_signaling_tb_top;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_lock_i = 1'b0;
	logic vcc_ok_i = 1'b1;
	logic can_rx_bus_i = 1'b1;
	logic lin_rx_bus_i = 1'b1;
	logic [7:0] sys_evt_i = 8'h00;
	logic [7:0] trx_evt_i = 8'h00;
	logic [7:0] wake_evt_i = 8'h00;
	logic [6:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, v, en_t, en_w, es, et, ew;
	logic reg_wr_i, reg_rd_i, rxd_o, rxd_lin_o, holdoff_busy_o;
	logic [1:0] can_state_o, lin_state_o;
	logic [2:0] dev_mode_o;
	int err_count = 0;
	int n_checks = 0;
	// core clock, 25 ns period
	always #12.5 sys_clk_i = ~sys_clk_i;
	event_capture_and_signaling #(.HOLDOFF_CYCLES(8)) dut_u (.sys_clk_i, .rst_n_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .wr_lock_i, .reg_rdata_o, .sys_evt_i, .trx_evt_i,
		.wake_evt_i, .vcc_ok_i, .can_rx_bus_i, .lin_rx_bus_i, .rxd_o, .rxd_lin_o,
		.can_state_o, .lin_state_o, .dev_mode_o, .holdoff_busy_o);
	evt_host_model host_u (.sys_clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i),
		.wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
	// bus bit streams change at random so a stuck pin shows
	always @(posedge sys_clk_i)
	begin
		can_rx_bus_i <= 1'($urandom);
		lin_rx_bus_i <= 1'($urandom);
	end
	function automatic logic [7:0] cap(input logic [7:0] e, input logic [7:0] en,
		input logic [7:0] m);
		return e & (en | m);
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		host_u.rd_reg(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask
	task automatic pins(input logic [1:0] e);
		chk("pins", {6'h00, e}, {6'h00, rxd_o, rxd_lin_o});
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// one-cycle event pulse on all three groups
	task automatic pulse(input logic [7:0] s, input logic [7:0] t, input logic [7:0] w);
		@(posedge sys_clk_i);
		sys_evt_i <= s;
		trx_evt_i <= t;
		wake_evt_i <= w;
		@(posedge sys_clk_i);
		sys_evt_i <= 8'h00;
		trx_evt_i <= 8'h00;
		wake_evt_i <= 8'h00;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, far beyond the fewer than two thousand cycles the run needs
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		complete_run();
	end
	// main sequence
	initial
	begin
		void'($urandom(32'h4f39));
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		host_u.wr_reg(7'h7e, 8'ha5);
		rchk(7'h7e, 8'h51);
		rchk(7'h3f, 8'h00);
		pulse(8'h00, 8'h0f, 8'h03);
		settle(1);
		pins(2'b00);
		rchk(7'h63, 8'h0c);
		rchk(7'h64, 8'h00);
		rchk(7'h60, 8'h02);
		rchk(7'h63, 8'h0c);
		// clearing one bit releases the pins and starts the hold-off
		host_u.wr_reg(7'h63, 8'h04);
		#1;
		chk("busy", 8'h01, {7'h00, holdoff_busy_o});
		pins(2'b11);
		rchk(7'h63, 8'h08);
		pulse(8'h80, 8'h00, 8'h00);
		#1;
		pins(2'b11);
		settle(6);
		pins(2'b00);
		rchk(7'h61, 8'h80);
		host_u.ack_reg(7'h61, v);
		host_u.ack_reg(7'h63, v);
		settle(12);
		pins(2'b11);
		// without vcc the pins stay high although an event is pending
		@(posedge sys_clk_i);
		vcc_ok_i <= 1'b0;
		pulse(8'h01, 8'h00, 8'h00);
		settle(3);
		pins(2'b11);
		@(posedge sys_clk_i);
		vcc_ok_i <= 1'b1;
		settle(2);
		pins(2'b00);
		host_u.ack_reg(7'h61, v);
		// random enables, lock and events, each pass read back and acknowledged
		en_t = 8'h00;
		en_w = 8'h00;
		for (int i = 0; i < 40; i++)
		begin
			@(posedge sys_clk_i);
			wr_lock_i <= 1'($urandom);
			v = 8'($urandom);
			host_u.wr_reg(7'h23, v);
			en_t = wr_lock_i ? en_t : v;
			v = 8'($urandom);
			host_u.wr_reg(7'h4c, v);
			en_w = wr_lock_i ? en_w : v;
			es = 8'($urandom);
			et = 8'($urandom);
			ew = 8'($urandom);
			pulse(es, et, ew);
			rchk(7'h61, cap(es, 8'h00, 8'hff));
			rchk(7'h63, cap(et, en_t, 8'h0c));
			rchk(7'h64, cap(ew, en_w, 8'h00));
			rchk(7'h60, {5'h00, |cap(ew, en_w, 8'h00), |cap(et, en_t, 8'h0c), |es});
			host_u.ack_reg(7'h61, v);
			host_u.ack_reg(7'h63, v);
			host_u.ack_reg(7'h64, v);
			rchk(7'h60, 8'h00);
		end
		// sleep only with a regular wake source enabled and nothing pending
		@(posedge sys_clk_i);
		wr_lock_i <= 1'b0;
		host_u.wr_reg(7'h23, 8'h00);
		host_u.wr_reg(7'h4c, 8'h00);
		host_u.wr_reg(7'h01, 8'h01);
		#1;
		chk("mode", 8'h04, {5'h00, dev_mode_o});
		host_u.wr_reg(7'h4c, 8'h01);
		host_u.wr_reg(7'h01, 8'h01);
		#1;
		chk("mode", 8'h01, {5'h00, dev_mode_o});
		pulse(8'h00, 8'h04, 8'h00);
		settle(2);
		chk("mode", 8'h04, {5'h00, dev_mode_o});
		host_u.wr_reg(7'h01, 8'h01);
		#1;
		chk("mode", 8'h04, {5'h00, dev_mode_o});
		host_u.ack_reg(7'h63, v);
		// transceiver states for every field value, normal then standby
		for (int m = 0; m < 2; m++)
		begin
			host_u.wr_reg(7'h01, m ? 8'h04 : 8'h07);
			for (int f = 0; f < 4; f++)
			begin
				host_u.wr_reg(7'h22, 8'(f));
				host_u.wr_reg(7'h26, 8'(f));
				settle(4);
				chk("can", (m == 0 || f == 2) ? 8'(f) : 8'h00, {6'h00, can_state_o});
				chk("lin", (m == 0 && f == 2) ? 8'h02 : 8'h00, {6'h00, lin_state_o});
			end
		end
		// a second reset in mid-run brings back the idle values
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk("rdata", 8'h00, reg_rdata_o);
		chk("mode", 8'h04, {5'h00, dev_mode_o});
		chk("busy", 8'h00, {7'h00, holdoff_busy_o});
		pins(2'b11);
		rchk(7'h4c, 8'h00);
		complete_run();
	end
endmodule
